// ===== rtl/lbbc_regs.vh
`ifndef LBBC_REGS_VH
`define LBBC_REGS_VH
// register addresses
`define LBBC_ADDR_GEN_CTRL 8'h10
`define LBBC_ADDR_MAIN_BRIGHT 8'hA0
`define LBBC_ADDR_IND_BRIGHT 8'hC0
// reset values
`define LBBC_RST_GEN_CTRL 8'h20
`define LBBC_RST_MAIN_BRIGHT 8'hE0
`define LBBC_RST_IND_BRIGHT 8'hFC
// general control fields
`define LBBC_GC_MAIN_EN 0
`define LBBC_GC_TEST_LOW 1
`define LBBC_GC_IND_EN 2
`define LBBC_GC_SENSE_EN 3
`define LBBC_GC_TEST_HIGH 4
// pwm timing
`define LBBC_CLK_HZ 200000000
`define LBBC_PWM_HZ 20000
`define LBBC_PWM_PERIOD_CYC (`LBBC_CLK_HZ / `LBBC_PWM_HZ)
`define LBBC_PWM_SLOT_CYC (`LBBC_PWM_PERIOD_CYC / 16)
`endif

// ===== rtl/lbbc_top.v
// Notes on behaviour
// - acknowledge every received byte on ninth pulse, except a chip address that does not match
// - direction bit 0 write, 1 read
// - second byte register address, third byte data
// - address 10h is general control register
// - A0h main brightness, C0h indicator brightness
// - bit 0 enables main sinks
// - bit 2 enables indicator sink
// - bit 3 enables fifth sink voltage sensing
// - low five bits form main code
// - unused brightness bits have no effect
// - main code maps to level and duty
// - main pwm runs at fixed 20kHz
// - indicator code picks analog level only
// - reset pin low restores defaults, disables
`timescale 1ns/1ps
`default_nettype none
`include "lbbc_regs.vh"
module lbbc_top #(
  parameter [6:0] CHIP_ADDR = 7'h2A, // arbitrary value
  parameter PWM_SLOT_CYC = `LBBC_PWM_SLOT_CYC
) (
  input wire CLK_SYS_IN,
  input wire RST_IN,
  input wire RESET_N_IN,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE_OUT,
  output reg MAIN_SINK_ON_OUT,
  output reg [1:0] MAIN_LEVEL_OUT,
  output reg IND_SINK_ON_OUT,
  output reg [1:0] IND_LEVEL_OUT,
  output reg FIFTH_SENSE_ON_OUT
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg [2:0] rstn_sync_reg;
  reg scl_reg;
  reg sda_reg;
  reg rstn_reg;
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      rstn_sync_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      rstn_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN};
      rstn_sync_reg <= {rstn_sync_reg[1:0], RESET_N_IN};
      // a change counts once stages two and three agree
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
      if (rstn_sync_reg[1] == rstn_sync_reg[2]) begin
        rstn_reg <= rstn_sync_reg[2];
      end
    end
  end
  reg scl_d_reg;
  reg sda_d_reg;
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_reg;
      sda_d_reg <= sda_reg;
    end
  end
  wire scl_rise = scl_reg & ~scl_d_reg;
  wire scl_fall = ~scl_reg & scl_d_reg;
  wire start_ev = scl_reg & scl_d_reg & sda_d_reg & ~sda_reg;
  wire stop_ev = scl_reg & scl_d_reg & ~sda_d_reg & sda_reg;
  wire dev_rst = RST_IN | ~rstn_reg;

  // ****************************************
  // serial slave
  // ****************************************
  localparam ST_IDLE = 3'd0;
  localparam ST_CHIP = 3'd1;
  localparam ST_REG = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_READ = 3'd4;
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg byte_done_reg;
  reg [7:0] shift_reg;
  reg in_ack_reg;
  reg drive_low_reg;
  reg master_nack_reg;
  reg [7:0] reg_ptr_reg;
  reg [7:0] gen_ctrl_reg;
  reg [7:0] main_bright_reg;
  reg [7:0] ind_bright_reg;
  reg [7:0] rd_data;
  always @* begin
    if (reg_ptr_reg == `LBBC_ADDR_GEN_CTRL) begin
      rd_data = gen_ctrl_reg;
    end else if (reg_ptr_reg == `LBBC_ADDR_MAIN_BRIGHT) begin
      rd_data = main_bright_reg;
    end else if (reg_ptr_reg == `LBBC_ADDR_IND_BRIGHT) begin
      rd_data = ind_bright_reg;
    end else begin
      rd_data = 8'h00;
    end
  end
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = drive_low_reg;
  always @(posedge CLK_SYS_IN) begin
    if (dev_rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      shift_reg <= 8'h00;
      in_ack_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      master_nack_reg <= 1'b0;
      reg_ptr_reg <= 8'h00;
      gen_ctrl_reg <= `LBBC_RST_GEN_CTRL;
      main_bright_reg <= `LBBC_RST_MAIN_BRIGHT;
      ind_bright_reg <= `LBBC_RST_IND_BRIGHT;
    end else if (start_ev) begin
      // restart also begins a new address byte
      state_reg <= ST_CHIP;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      in_ack_reg <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= ST_IDLE;
      drive_low_reg <= 1'b0;
    end else if (state_reg != ST_IDLE) begin
      if (scl_rise) begin
        if (in_ack_reg) begin
          master_nack_reg <= sda_reg;
        end else begin
          // bits count on rises: the fall after a start is no bit
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          byte_done_reg <= (bit_cnt_reg == 3'h7);
          if (state_reg != ST_READ) begin
            shift_reg <= {shift_reg[6:0], sda_reg};
          end
        end
      end else if (scl_fall) begin
        if (in_ack_reg) begin
          in_ack_reg <= 1'b0;
          drive_low_reg <= 1'b0;
          if (state_reg == ST_READ) begin
            if (master_nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              shift_reg <= rd_data;
              drive_low_reg <= ~rd_data[7];
            end
          end
        end else if (byte_done_reg) begin
          byte_done_reg <= 1'b0;
          in_ack_reg <= 1'b1;
          drive_low_reg <= (state_reg != ST_READ);
          case (state_reg)
            ST_CHIP: begin
              if (shift_reg[7:1] != CHIP_ADDR) begin
                state_reg <= ST_IDLE;
                drive_low_reg <= 1'b0;
                in_ack_reg <= 1'b0;
              end else if (shift_reg[0]) begin
                state_reg <= ST_READ;
              end else begin
                state_reg <= ST_REG;
              end
            end
            ST_REG: begin
              reg_ptr_reg <= shift_reg;
              state_reg <= ST_DATA;
            end
            ST_DATA: begin
              if (reg_ptr_reg == `LBBC_ADDR_GEN_CTRL) begin
                gen_ctrl_reg <= shift_reg;
              end else if (reg_ptr_reg == `LBBC_ADDR_MAIN_BRIGHT) begin
                main_bright_reg <= shift_reg;
              end else if (reg_ptr_reg == `LBBC_ADDR_IND_BRIGHT) begin
                ind_bright_reg <= shift_reg;
              end
            end
            default: begin
              state_reg <= state_reg;
            end
          endcase
        end else if (state_reg == ST_READ) begin
          shift_reg <= {shift_reg[6:0], 1'b0};
          drive_low_reg <= ~shift_reg[6];
        end
      end
    end
  end

  // ****************************************
  // main bank pwm
  // ****************************************
  localparam [15:0] SLOT_LAST = PWM_SLOT_CYC[15:0] - 16'h0001;
  reg [15:0] slot_cnt_reg;
  reg [3:0] phase_reg;
  always @(posedge CLK_SYS_IN) begin
    if (dev_rst) begin
      slot_cnt_reg <= 16'h0000;
      phase_reg <= 4'h0;
    end else if (slot_cnt_reg == SLOT_LAST) begin
      slot_cnt_reg <= 16'h0000;
      phase_reg <= phase_reg + 4'h1;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 16'h0001;
    end
  end
  wire [4:0] main_code = main_bright_reg[4:0];
  reg [1:0] level;
  reg [3:0] duty_m1;
  always @* begin
    // level and duty per code; duty_m1 is on-slots minus one
    if (main_code <= 5'h0F) begin
      level = 2'd0;
      duty_m1 = main_code[3:0];
    end else if (main_code <= 5'h16) begin
      level = 2'd1;
      duty_m1 = main_code[3:0] + 4'd9;
    end else if (main_code <= 5'h1C) begin
      level = 2'd2;
      duty_m1 = main_code[3:0] + 4'd3;
    end else if (main_code == 5'h1D) begin
      level = 2'd3;
      duty_m1 = 4'd12;
    end else if (main_code == 5'h1E) begin
      level = 2'd3;
      duty_m1 = 4'd14;
    end else begin
      level = 2'd3;
      duty_m1 = 4'd15;
    end
  end
  // code taken at period start only: a mid-period change leaves no runt pulse
  reg [3:0] duty_m1_reg;
  reg [1:0] level_reg;
  always @(posedge CLK_SYS_IN) begin
    if (dev_rst) begin
      duty_m1_reg <= 4'h0;
      level_reg <= 2'h0;
    end else if (slot_cnt_reg == SLOT_LAST && phase_reg == 4'hF) begin
      duty_m1_reg <= duty_m1;
      level_reg <= level;
    end
  end
  always @(posedge CLK_SYS_IN) begin
    if (dev_rst) begin
      MAIN_SINK_ON_OUT <= 1'b0;
      MAIN_LEVEL_OUT <= 2'd0;
      IND_SINK_ON_OUT <= 1'b0;
      IND_LEVEL_OUT <= 2'd0;
      FIFTH_SENSE_ON_OUT <= 1'b0;
    end else begin
      MAIN_SINK_ON_OUT <= gen_ctrl_reg[`LBBC_GC_MAIN_EN] & (phase_reg <= duty_m1_reg);
      MAIN_LEVEL_OUT <= level_reg;
      IND_SINK_ON_OUT <= gen_ctrl_reg[`LBBC_GC_IND_EN];
      IND_LEVEL_OUT <= ind_bright_reg[1:0];
      FIFTH_SENSE_ON_OUT <= gen_ctrl_reg[`LBBC_GC_SENSE_EN];
    end
  end
endmodule
`default_nettype wire

// ===== test/lbbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// bus master
// ********
module lbbc_host_model (
  input wire logic clk,
  input wire logic sda,
  output var logic scl = 1'b1,
  output var logic sdm = 1'b1
);
  task automatic q;
    repeat (4) @(negedge clk);
  endtask
  // start is cond(1,0), stop is cond(0,1)
  task automatic cond(input logic a, input logic b);
    scl = 1'b0;
    q;
    sdm = a;
    q;
    scl = 1'b1;
    q;
    sdm = b;
    q;
  endtask
  // data changes only while clock low
  task automatic bt(input logic b, output logic s);
    scl = 1'b0;
    q;
    sdm = b;
    q;
    scl = 1'b1;
    q;
    s = sda;
    q;
  endtask
  task automatic by(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      bt(d[i], r[i]);
    bt(a, k);
  endtask
endmodule
`default_nettype wire

// ===== test/lbbc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// pin checks
// ********
module lbbc_monitor (
  input wire CLK_SYS_IN,
  input wire RST_IN,
  input wire RESET_N_IN,
  input wire SCL_IN,
  input wire SDA_OUT,
  input wire SDA_OE_OUT,
  input wire MAIN_SINK_ON_OUT,
  input wire [1:0] MAIN_LEVEL_OUT,
  input wire IND_SINK_ON_OUT,
  input wire [1:0] IND_LEVEL_OUT,
  input wire FIFTH_SENSE_ON_OUT
);
  default clocking @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);
  wire off = !MAIN_SINK_ON_OUT && !IND_SINK_ON_OUT && !FIFTH_SENSE_ON_OUT && !SDA_OE_OUT;
  open_drain_a: assert property (!SDA_OUT)
    else $error("data pin driven high");
  ack_edge_a: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
    else $error("data moved with clock high");
  ack_hold_a: assert property ($rose(SDA_OE_OUT) |=> SDA_OE_OUT [*8])
    else $error("ack too short");
  ack_bound_a: assert property ($rose(SDA_OE_OUT) |-> ##[1:200] !SDA_OE_OUT)
    else $error("data line never released");
  pin_reset_a: assert property (!RESET_N_IN [*6] |-> off)
    else $error("outputs on in pin reset");
  level_reset_a: assert property (!RESET_N_IN [*6] |-> !MAIN_LEVEL_OUT && !IND_LEVEL_OUT)
    else $error("levels not cleared");
  sys_reset_a: assert property (disable iff (1'b0) RST_IN |=> off)
    else $error("outputs on in reset");
  pwm_gap_a: assert property ($fell(MAIN_SINK_ON_OUT) |-> !MAIN_SINK_ON_OUT [*4])
    else $error("off time under one slot");
  cover property ($rose(SDA_OE_OUT));
  cover property ($fell(MAIN_SINK_ON_OUT));
  cover property (!RESET_N_IN [*6]);
endmodule
bind lbbc_top lbbc_monitor u_mon (.CLK_SYS_IN, .RST_IN, .RESET_N_IN, .SCL_IN, .SDA_OUT,
  .SDA_OE_OUT, .MAIN_SINK_ON_OUT, .MAIN_LEVEL_OUT, .IND_SINK_ON_OUT, .IND_LEVEL_OUT,
  .FIFTH_SENSE_ON_OUT);
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// ********
// bench
// ********
module tb;
  localparam logic [6:0] ADR = 7'h2A; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_n = 1'b1;
  logic scl, sdm, oe, sdo, mon, ion, fon, k;
  logic [1:0] mlv, ilv, lv;
  logic [7:0] r, v;
  int errors = 0;
  int total_checks = 0;
  int n, d;
  // pull-up on the shared data line
  wire sda = sdm & ~oe;
  always #2.5 clk = ~clk;
  lbbc_host_model m (.clk(clk), .sda(sda), .scl(scl), .sdm(sdm));
  lbbc_top #(.CHIP_ADDR(ADR), .PWM_SLOT_CYC(4)) dut (.CLK_SYS_IN(clk), .RST_IN(rst),
    .RESET_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE_OUT(oe),
    .MAIN_SINK_ON_OUT(mon), .MAIN_LEVEL_OUT(mlv), .IND_SINK_ON_OUT(ion),
    .IND_LEVEL_OUT(ilv), .FIFTH_SENSE_ON_OUT(fon));
  task automatic hdr(input logic [7:0] a);
    m.cond(1'b1, 1'b0);
    m.by({ADR, 1'b0}, 1'b1, r, k);
    `CHK(k, 1'b0)
    m.by(a, 1'b1, r, k);
    `CHK(k, 1'b0)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    hdr(a);
    m.by(x, 1'b1, r, k);
    `CHK(k, 1'b0)
    m.cond(1'b0, 1'b1);
    repeat (20) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    hdr(a);
    m.cond(1'b1, 1'b0);
    m.by({ADR, 1'b1}, 1'b1, r, k);
    `CHK(k, 1'b0)
    m.by(8'hFF, 1'b1, v, k);
    m.cond(1'b0, 1'b1);
    `CHK(v, e)
  endtask
  task automatic t_defaults;
    rd(8'h10, 8'h20);
    rd(8'hA0, 8'hE0);
    rd(8'hC0, 8'hFC);
    `CHK({mon, ion, fon, mlv, ilv}, 7'h00)
  endtask
  task automatic t_gen;
    wr(8'h10, 8'h0D);
    `CHK({ion, fon}, 2'b11)
    wr(8'h10, 8'h05);
    `CHK({ion, fon}, 2'b10)
    wr(8'h10, 8'h01);
    `CHK({ion, fon}, 2'b00)
    rd(8'h10, 8'h01);
  endtask
  task automatic t_main;
    for (int c = 0; c < 32; c++) begin
      wr(8'hA0, {3'b111, c[4:0]});
      d = c < 16 ? c + 1 : c < 23 ? c - 6 : c < 29 ? c - 12 : c == 31 ? 16 : 2 * c - 45;
      lv = c < 16 ? 2'd0 : c < 23 ? 2'd1 : c < 29 ? 2'd2 : 2'd3;
      // a new code starts at the next period
      repeat (64) @(negedge clk);
      n = 0;
      // one full pwm period of 16 slots
      repeat (64) begin
        @(negedge clk);
        if (mon === 1'b1)
          n++;
      end
      `CHK(n, 4 * d)
      `CHK(mlv, lv)
    end
  endtask
  task automatic t_ind;
    wr(8'h10, 8'h04);
    for (int c = 0; c < 4; c++) begin
      wr(8'hC0, {6'h3F, c[1:0]});
      `CHK({ilv, ion, mon}, {c[1:0], 2'b10})
    end
  endtask
  task automatic t_misc;
    m.cond(1'b1, 1'b0);
    m.by({ADR ^ 7'h01, 1'b0}, 1'b1, r, k);
    m.cond(1'b0, 1'b1);
    `CHK(k, 1'b1)
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    `CHK({mon, ion, fon}, 3'b000)
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    rd(8'h10, 8'h20);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_defaults;
    t_gen;
    t_main;
    t_ind;
    t_misc;
    end_of_test;
  end
  // whole run needs about 140 us
  initial begin
    #400000;
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
